// ---- src/frag_tx.sv ----
// Segmenting end with its payload FIFO
`timescale 1ns/1ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wptr;
	logic [AW:0]      rptr;
	logic [AW:0]      next_wptr;
	logic [AW:0]      next_rptr;
	logic             push;
	logic             pop;

	always_comb begin
		in_ready  = (wptr - rptr) != (AW+1)'(DEPTH);
		out_valid = wptr != rptr;
		push      = in_valid && in_ready;
		pop       = out_valid && out_ready;
		next_wptr = push ? wptr + 1'b1 : wptr;
		next_rptr = pop ? rptr + 1'b1 : rptr;
	end
	assign out_data = mem[rptr[AW-1:0]];

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wptr <= '0;
			rptr <= '0;
		end else begin
			wptr <= next_wptr;
			rptr <= next_rptr;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wptr[AW-1:0]] <= in_data;
		end
	end
endmodule : byte_fifo

module frag_tx import ecl_pkg::*; (
	input  wire logic              ref_clk,
	input  wire logic              srst,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [31:0]       wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic      [31:0]       rdata,
	input  wire logic [7:0]        in_data,
	input  wire logic              in_valid,
	output logic                   in_ready,
	ecl_link_if.tx                 link
);
	tx_state_t   state;
	tx_state_t   next_state;
	logic        multi, next_multi;
	logic        up, next_up;
	logic [23:0] tag, next_tag;
	logic [12:0] len, next_len;
	logic [12:0] frag, next_frag;
	logic        refused, next_refused;
	logic [1:0]  idx, next_idx;
	logic [12:0] remain, next_remain;
	logic [12:0] pay, next_pay;
	logic        first, next_first;
	logic [7:0]  l_data, next_l_data;
	logic        l_valid, next_l_valid;
	logic        l_last, next_l_last;
	logic [31:0] next_rdata;
	logic [7:0]  f_data;
	logic        f_valid;
	logic        f_pop;
	logic        start;
	logic        e_multi;
	logic        e_up;
	logic [12:0] limit;
	logic        adv;
	logic        is_last;
	logic [12:0] this_len;

	// Payload bytes wait here; a stall on the link backs up to in_ready
	byte_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk   (ref_clk),
		.srst      (srst),
		.in_data   (in_data),
		.in_valid  (in_valid),
		.in_ready  (in_ready),
		.out_data  (f_data),
		.out_valid (f_valid),
		.out_ready (f_pop)
	);

	assign link.data  = l_data;
	assign link.valid = l_valid;
	assign link.last  = l_last;

	always_comb begin
		next_state   = state;
		next_multi   = multi;
		next_up      = up;
		next_tag     = tag;
		next_len     = len;
		next_frag    = frag;
		next_refused = refused;
		next_idx     = idx;
		next_remain  = remain;
		next_pay     = pay;
		next_first   = first;
		next_l_data  = l_data;
		next_l_last  = l_last;
		next_l_valid = l_valid && !link.ready;
		next_rdata   = 32'h0;
		f_pop        = 1'b0;
		adv          = !l_valid || link.ready;
		start        = wr && addr == TX_CTRL && wdata[CTRL_START];
		e_multi      = start ? wdata[CTRL_MULTI] : multi;
		e_up         = start ? wdata[CTRL_UP] : up;
		limit        = e_up ? MAX_UP : MAX_DOWN;
		is_last      = remain <= frag;
		this_len     = is_last ? remain : frag;
		// Configuration is frozen while a datagram is in flight
		if (wr && state == TX_IDLE) begin
			unique case (addr)
				TX_CTRL: begin
					next_multi = wdata[CTRL_MULTI];
					next_up    = wdata[CTRL_UP];
				end
				TX_TAG:  next_tag  = wdata[23:0];
				TX_LEN:  next_len  = wdata[12:0];
				TX_FRAG: next_frag = wdata[12:0];
				default: ;
			endcase
		end
		if (wr && addr == TX_STAT && wdata[ST_REFUSED]) begin
			next_refused = 1'b0;
		end
		if (rd) begin
			unique case (addr)
				TX_CTRL: next_rdata = {30'h0, up, multi};
				TX_TAG:  next_rdata = {8'h0, tag};
				TX_LEN:  next_rdata = {19'h0, len};
				TX_FRAG: next_rdata = {19'h0, frag};
				TX_STAT: next_rdata = {30'h0, refused, state != TX_IDLE};
				default: next_rdata = 32'h0;
			endcase
		end
		unique case (state)
			TX_IDLE: begin
				if (start) begin
					// M headers carry no flags, so one packet per datagram
					if (tag == 24'h0 || len == 13'h0 || len > limit ||
					    frag == 13'h0 || (e_multi && len > frag)) begin
						next_refused = 1'b1;
					end else begin
						next_state  = TX_HDR;
						next_idx    = 2'h0;
						next_remain = len;
						next_first  = 1'b1;
					end
				end
			end
			TX_HDR: begin
				if (adv) begin
					next_l_valid = 1'b1;
					next_l_last  = 1'b0;
					next_idx     = idx + 2'h1;
					unique case (idx)
						2'h0: next_l_data = multi ? 8'h00 :
							{is_last, first, 6'h00};
						2'h1: next_l_data = tag[23:16];
						2'h2: next_l_data = tag[15:8];
						2'h3: next_l_data = tag[7:0];
						default: ;
					endcase
					if (idx == 2'h3) begin
						next_state = TX_PAY;
						next_pay   = this_len;
					end
				end
			end
			TX_PAY: begin
				if (adv && f_valid) begin
					f_pop        = 1'b1;
					next_l_valid = 1'b1;
					next_l_data  = f_data;
					next_l_last  = pay == 13'h1;
					next_pay     = pay - 13'h1;
					next_remain  = remain - 13'h1;
					if (pay == 13'h1) begin
						next_idx   = 2'h0;
						next_first = 1'b0;
						next_state = remain == 13'h1 ? TX_IDLE : TX_HDR;
					end
				end
			end
			default: next_state = TX_IDLE;
		endcase
		// A refusal in the same cycle as its clear is kept
		if (state == TX_IDLE && start && next_state == TX_IDLE) begin
			next_refused = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state   <= TX_IDLE;
			multi   <= 1'b0;
			up      <= 1'b0;
			tag     <= TAG_RST;
			len     <= 13'h0;
			frag    <= FRAG_RST;
			refused <= 1'b0;
			idx     <= 2'h0;
			remain  <= 13'h0;
			pay     <= 13'h0;
			first   <= 1'b0;
			l_data  <= 8'h0;
			l_valid <= 1'b0;
			l_last  <= 1'b0;
			rdata   <= 32'h0;
		end else begin
			state   <= next_state;
			multi   <= next_multi;
			up      <= next_up;
			tag     <= next_tag;
			len     <= next_len;
			frag    <= next_frag;
			refused <= next_refused;
			idx     <= next_idx;
			remain  <= next_remain;
			pay     <= next_pay;
			first   <= next_first;
			l_data  <= next_l_data;
			l_valid <= next_l_valid;
			l_last  <= next_l_last;
			rdata   <= next_rdata;
		end
	end
endmodule : frag_tx

// ---- src/ecl_pkg.sv ----
// Shared constants and types for the link fragmenter ends
// How it works
// - S header byte: bit7 last, bit6 first
// - Last flag clear until final fragment
// - First flag only on opening fragment
// - Three-byte stream tag, MSB first, then payload
// - Stream tag zero never used
// - M header: zero byte plus tag
// - Producer segments, consumer reassembles
// - Rebuild per category of stream tag; code rebuilds one RX_TAG stream, category from RX_CAT
// - Reassembly never exceeds 4096 bytes
// - Fragments no larger than buffer size
// - Downstream datagram at most 4096 bytes
// - Upstream datagram over 1500 refused
package ecl_pkg;
	localparam int          ADDR_W     = 3;
	localparam int          FIFO_W     = 8;
	localparam int          FIFO_DEPTH = 8;
	localparam int          LEN_W      = 13;
	localparam logic [12:0] MAX_DOWN   = 13'h1000;
	localparam logic [12:0] MAX_UP     = 13'h05dc;
	localparam logic [12:0] MAX_DGRAM  = 13'h1000;
	localparam int          LAST_BIT   = 7;
	localparam int          FIRST_BIT  = 6;
	// Register offsets, segmenting end
	localparam logic [2:0]  TX_CTRL    = 3'h0;
	localparam logic [2:0]  TX_TAG     = 3'h1;
	localparam logic [2:0]  TX_LEN     = 3'h2;
	localparam logic [2:0]  TX_FRAG    = 3'h3;
	localparam logic [2:0]  TX_STAT    = 3'h4;
	// Register offsets, reassembling end
	localparam logic [2:0]  RX_CTRL    = 3'h0;
	localparam logic [2:0]  RX_TAG     = 3'h1;
	localparam logic [2:0]  RX_CAT     = 3'h2;
	localparam logic [2:0]  RX_LEN     = 3'h3;
	localparam logic [2:0]  RX_STAT    = 3'h4;
	// Field positions
	localparam int          CTRL_MULTI = 0;
	localparam int          CTRL_UP    = 1;
	localparam int          CTRL_START = 2;
	localparam int          ST_BUSY    = 0;
	localparam int          ST_REFUSED = 1;
	localparam int          ST_ORPHAN  = 1;
	localparam int          ST_OVER    = 2;
	localparam int          ST_TAGERR  = 3;
	// Values after reset
	localparam logic [12:0] FRAG_RST   = 13'h0100;
	localparam logic [23:0] TAG_RST    = 24'h000000;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_HDR  = 2'b01,
		TX_PAY  = 2'b10
	} tx_state_t;

	typedef enum logic [1:0] {
		RX_HDR   = 2'b00,
		RX_PAY   = 2'b01,
		RX_DRAIN = 2'b10
	} rx_state_t;

	typedef enum logic [1:0] {
		CAT_IP      = 2'h0,
		CAT_SECTION = 2'h1,
		CAT_TUNNEL  = 2'h2
	} category_t;
endpackage : ecl_pkg

// ---- src/ecl_link_if.sv ----
// Byte link between the segmenting and reassembling ends
`timescale 1ns/1ps
interface ecl_link_if;
	logic [7:0] data;
	logic       valid;
	logic       ready;
	logic       last;
	modport tx (output data, output valid, output last, input ready);
	modport rx (input data, input valid, input last, output ready);
endinterface : ecl_link_if

// ---- src/frag_rx.sv ----
// Reassembling end with its datagram buffer
`timescale 1ns/1ps
module frag_rx import ecl_pkg::*; (
	input  wire logic              ref_clk,
	input  wire logic              srst,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [31:0]       wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic      [31:0]       rdata,
	output logic      [7:0]        out_data,
	output logic                   out_valid,
	output logic                   out_last,
	output category_t              out_cat,
	input  wire logic              out_ready,
	ecl_link_if.rx                 link
);
	logic [7:0]  mem [4096];
	rx_state_t   state, next_state;
	logic        multi, next_multi;
	logic [23:0] tag, next_tag;
	category_t   cat, next_cat;
	category_t   next_out_cat;
	logic [3:1]  err, next_err;
	logic [12:0] dlen, next_dlen;
	logic [1:0]  idx, next_idx;
	logic [15:0] hi, next_hi;
	logic        f_last, next_f_last;
	logic        f_first, next_f_first;
	logic        active, next_active;
	logic        drop, next_drop;
	logic [12:0] wptr, next_wptr;
	logic [12:0] rptr, next_rptr;
	logic        next_out_valid;
	logic        next_out_last;
	logic [31:0] next_rdata;
	logic        take;
	logic        we;
	logic        load;
	logic [23:0] full_tag;
	logic [3:1]  set;

	assign link.ready = state != RX_DRAIN;

	always_comb begin
		next_state     = state;
		next_multi     = multi;
		next_tag       = tag;
		next_cat       = cat;
		next_out_cat   = out_cat;
		next_dlen      = dlen;
		next_idx       = idx;
		next_hi        = hi;
		next_f_last    = f_last;
		next_f_first   = f_first;
		next_active    = active;
		next_drop      = drop;
		next_wptr      = wptr;
		next_rptr      = rptr;
		next_out_valid = out_valid && !out_ready;
		next_out_last  = out_last;
		next_rdata     = 32'h0;
		set            = 3'h0;
		we             = 1'b0;
		load           = 1'b0;
		take           = link.valid && link.ready;
		full_tag       = {hi, link.data};
		if (wr) begin
			unique case (addr)
				RX_CTRL: next_multi = wdata[CTRL_MULTI];
				RX_TAG:  next_tag   = wdata[23:0];
				RX_CAT:  next_cat   = category_t'(wdata[1:0]);
				default: ;
			endcase
		end
		if (rd) begin
			unique case (addr)
				RX_CTRL: next_rdata = {31'h0, multi};
				RX_TAG:  next_rdata = {8'h0, tag};
				RX_CAT:  next_rdata = {30'h0, cat};
				RX_LEN:  next_rdata = {19'h0, dlen};
				RX_STAT: next_rdata = {28'h0, err, state == RX_DRAIN};
				default: next_rdata = 32'h0;
			endcase
		end
		unique case (state)
			RX_HDR: begin
				if (take) begin
					next_idx = idx + 2'h1;
					unique case (idx)
						2'h0: begin
							next_f_last  = link.data[LAST_BIT];
							next_f_first = link.data[FIRST_BIT];
						end
						2'h1: next_hi[15:8] = link.data;
						2'h2: next_hi[7:0]  = link.data;
						2'h3: begin
							next_drop  = 1'b0;
							next_state = RX_PAY;
							// Only the registered stream is rebuilt
							if (full_tag == 24'h0 || full_tag != tag) begin
								next_drop = 1'b1;
								set[ST_TAGERR] = 1'b1;
							end else if (multi || f_first) begin
								next_wptr   = 13'h0;
								next_active = 1'b1;
							end else if (!active) begin
								next_drop = 1'b1;
								set[ST_ORPHAN] = 1'b1;
							end
						end
						default: ;
					endcase
					// Truncated header: packet ignored, reassembly kept
					if (link.last) begin
						next_idx   = 2'h0;
						next_state = RX_HDR;
					end
				end
			end
			RX_PAY: begin
				if (take) begin
					if (!drop && wptr == MAX_DGRAM) begin
						next_drop   = 1'b1;
						next_active = 1'b0;
						set[ST_OVER] = 1'b1;
					end else if (!drop) begin
						we        = 1'b1;
						next_wptr = wptr + 13'h1;
					end
					if (link.last) begin
						next_idx   = 2'h0;
						next_state = RX_HDR;
						if (!next_drop && (multi || f_last) &&
						    next_wptr != 13'h0) begin
							next_state   = RX_DRAIN;
							next_dlen    = next_wptr;
							next_rptr    = 13'h0;
							next_active  = 1'b0;
							next_out_cat = cat;
						end
					end
				end
			end
			RX_DRAIN: begin
				// The link is held off until the buffer is empty again
				if (!out_valid || out_ready) begin
					if (rptr != dlen) begin
						load           = 1'b1;
						next_out_valid = 1'b1;
						next_out_last  = rptr == dlen - 13'h1;
						next_rptr      = rptr + 13'h1;
					end else begin
						next_state = RX_HDR;
					end
				end
			end
			default: next_state = RX_HDR;
		endcase
		// Hardware set wins over a software clear
		next_err = (err & ~((wr && addr == RX_STAT) ? wdata[3:1] : 3'h0))
			| set;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state     <= RX_HDR;
			multi     <= 1'b0;
			tag       <= TAG_RST;
			cat       <= CAT_IP;
			out_cat   <= CAT_IP;
			err       <= 3'h0;
			dlen      <= 13'h0;
			idx       <= 2'h0;
			hi        <= 16'h0;
			f_last    <= 1'b0;
			f_first   <= 1'b0;
			active    <= 1'b0;
			drop      <= 1'b0;
			wptr      <= 13'h0;
			rptr      <= 13'h0;
			out_valid <= 1'b0;
			out_last  <= 1'b0;
			rdata     <= 32'h0;
		end else begin
			state     <= next_state;
			multi     <= next_multi;
			tag       <= next_tag;
			cat       <= next_cat;
			out_cat   <= next_out_cat;
			err       <= next_err;
			dlen      <= next_dlen;
			idx       <= next_idx;
			hi        <= next_hi;
			f_last    <= next_f_last;
			f_first   <= next_f_first;
			active    <= next_active;
			drop      <= next_drop;
			wptr      <= next_wptr;
			rptr      <= next_rptr;
			out_valid <= next_out_valid;
			out_last  <= next_out_last;
			rdata     <= next_rdata;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (we) begin
			mem[wptr[11:0]] <= link.data;
		end
		if (load) begin
			out_data <= mem[rptr[11:0]];
		end
	end
endmodule : frag_rx

// ---- dv/ecl_link_assertions.sv ----
// Link checker for the byte link between the two ends
`timescale 1ns/1ps
module ecl_link_assertions (
	input wire logic       ref_clk,
	input wire logic       srst,
	input wire logic [7:0] data,
	input wire logic       valid,
	input wire logic       ready,
	input wire logic       last
);
	logic [12:0] pos;
	logic [12:0] next_pos;
	logic        open;
	logic        next_open;
	logic [7:0]  hdr;
	logic [7:0]  tg1;
	logic [7:0]  tg2;
	logic        take;

	assign take = valid && ready;

	// Middle S fragments carry a zero byte like M packets, so keep state
	always_comb begin
		next_pos = pos;
		next_open = open;
		if (take) begin
			next_pos = last ? 13'h0 : pos + 13'h1;
			if (last && hdr == 8'h40)
				next_open = 1'b1;
			else if (last && hdr[7])
				next_open = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pos <= 13'h0;
			open <= 1'b0;
		end else begin
			pos <= next_pos;
			open <= next_open;
		end
		if (take && pos == 13'h0)
			hdr <= data;
		if (take && pos == 13'h1)
			tg1 <= data;
		if (take && pos == 13'h2)
			tg2 <= data;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	a_hold_data: assert property (valid && !ready |=> $stable(data) && $stable(last))
		else $error("link byte changed before taken");
	a_hold_valid: assert property (valid && !ready |=> valid)
		else $error("link valid dropped before taken");
	a_hdr_low_zero: assert property (valid && pos == 13'h0 |-> data[5:0] == 6'h0)
		else $error("header low bits not zero");
	a_no_early_last: assert property (valid && pos < 13'h4 |-> !last)
		else $error("packet ended inside header");
	a_tag_nonzero: assert property (take && pos == 13'h3 |-> {tg1, tg2, data} != 24'h0)
		else $error("zero stream tag sent");
	a_cont_no_first: assert property (valid && pos == 13'h0 && open |-> !data[6])
		else $error("first flag on continuation");
	a_new_has_first: assert property (valid && pos == 13'h0 && !open |-> data[6] || data == 8'h00)
		else $error("new datagram without first flag");
	a_size_cap: assert property (valid |-> pos < 13'd4100)
		else $error("packet longer than datagram limit");
endmodule : ecl_link_assertions

// ---- dv/tb_top.sv ----
// Bench joining the segmenting and reassembling ends
`timescale 1ns/1ps
module tb_top import ecl_pkg::*;;
	logic        ref_clk = 1'b0;
	logic        srst = 1'b1;
	logic [2:0]  addr = 3'h0;
	logic [31:0] wdata = 32'h0;
	logic [1:0]  wr = 2'h0;
	logic [1:0]  rd = 2'h0;
	logic [31:0] rdt [3];
	logic [7:0]  in_data = 8'h0;
	logic        in_valid = 1'b0;
	logic        in_ready;
	logic [7:0]  out_data;
	logic        out_valid;
	logic        out_last;
	category_t   out_cat;
	category_t   lcat;
	logic        out_ready = 1'b0;
	logic [1:0]  cyc = 2'h0;
	logic [7:0]  wq [$];
	logic [7:0]  oq [$];
	logic        lq [$];
	int          miscompares = 0;
	int          checked = 0;
	ecl_link_if  lnk();
	ecl_link_if  lk2();

	frag_tx i_frag_tx (.ref_clk, .srst, .addr, .wdata, .wr(wr[0]), .rd(rd[0]),
		.rdata(rdt[0]), .in_data, .in_valid, .in_ready, .link(lnk));
	frag_rx i_frag_rx (.ref_clk, .srst, .addr, .wdata, .wr(wr[1]), .rd(rd[1]),
		.rdata(rdt[1]), .out_data, .out_valid, .out_last, .out_cat,
		.out_ready, .link(lnk));
	// Second receiver faces a bench driver that breaks the link rules
	frag_rx i_frag_rx2 (.ref_clk, .srst, .addr, .wdata, .wr(wr[1]), .rd(rd[1]),
		.rdata(rdt[2]), .out_data(), .out_valid(), .out_last(), .out_cat(),
		.out_ready, .link(lk2));
	ecl_link_assertions u_chk (.ref_clk, .srst, .data(lnk.data),
		.valid(lnk.valid), .ready(lnk.ready), .last(lnk.last));

	always #25 ref_clk = ~ref_clk;

	// Consumer stalls one cycle in four to exercise back pressure
	always @(posedge ref_clk) begin
		cyc <= cyc + 2'h1;
		out_ready <= cyc != 2'h3;
		if (lnk.valid && lnk.ready)
			wq.push_back(lnk.data);
		if (out_valid && out_ready) begin
			oq.push_back(out_data);
			lq.push_back(out_last);
			if (out_last)
				lcat <= out_cat;
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, seen, exp);
		end
	endtask : check

	function logic [7:0] pb(input int i);
		return 8'(i * 7 + 3);
	endfunction : pb

	task wreg(input int s, input logic [2:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr[s] <= 1'b1;
		@(posedge ref_clk);
		wr <= 2'h0;
	endtask : wreg

	task rreg(input int s, input logic [2:0] a, output logic [31:0] v);
		@(posedge ref_clk);
		addr <= a;
		rd[s > 0] <= 1'b1;
		@(posedge ref_clk);
		rd <= 2'h0;
		#1 v = rdt[s];
	endtask : rreg

	task push(input int a, input int b);
		for (int i = a; i < b; i++) begin
			@(posedge ref_clk);
			in_data <= pb(i);
			in_valid <= 1'b1;
			@(negedge ref_clk);
			while (in_ready !== 1'b1) @(negedge ref_clk);
		end
		@(posedge ref_clk);
		in_valid <= 1'b0;
	endtask : push

	task sbyte(input logic [7:0] b, input logic l);
		@(posedge ref_clk);
		lk2.data <= b;
		lk2.last <= l;
		lk2.valid <= 1'b1;
		@(negedge ref_clk);
		while (lk2.ready !== 1'b1) @(negedge ref_clk);
	endtask : sbyte

	task snd(input logic [7:0] h, input logic [23:0] t, input int n);
		sbyte(h, 1'b0);
		sbyte(t[23:16], 1'b0);
		sbyte(t[15:8], 1'b0);
		sbyte(t[7:0], 1'b0);
		for (int i = 0; i < n; i++) sbyte(pb(i), i == n - 1);
		@(posedge ref_clk);
		lk2.valid <= 1'b0;
		lk2.last <= 1'b0;
		lk2.data <= ~lk2.data;
		repeat (20) @(posedge ref_clk);
	endtask : snd

	task run(input logic m, up, input logic [23:0] tag, input int len, frag,
		input logic ok);
		logic [31:0] v;
		int          j;
		wreg(0, TX_TAG, 32'(tag));
		wreg(0, TX_LEN, len);
		wreg(0, TX_FRAG, frag);
		wreg(1, RX_CTRL, 32'(m));
		wreg(1, RX_TAG, 32'(tag));
		wreg(1, RX_CAT, 32'(up));
		wq.delete();
		oq.delete();
		lq.delete();
		push(0, ok && len >= 8 ? 8 : 0);
		if (ok && len >= 8) #1 check(32'(in_ready), 32'h0);
		wreg(0, TX_CTRL, {29'h0, 1'b1, up, m});
		if (ok) push(len >= 8 ? 8 : 0, len);
		for (j = 0; j < 20000 && ok && oq.size() < len; j++) @(posedge ref_clk);
		rreg(0, TX_STAT, v);
		check(v[ST_REFUSED], !ok);
		wreg(0, TX_STAT, 32'h2);
		if (ok) begin
			check(32'(wq.size()), len + 4 * ((len + frag - 1) / frag));
			j = 0;
			for (int k = 0; k < len; k += frag) begin
				check(wq[j], m ? 8'h00 : {k + frag >= len, k == 0, 6'h0});
				check({wq[j+1], wq[j+2], wq[j+3]}, tag);
				for (int i = k; i < k + frag && i < len; i++)
					check(wq[j+4+i-k], pb(i));
				j += 4 + (len - k < frag ? len - k : frag);
			end
			check(32'(oq.size()), len);
			for (int i = 0; i < len; i++) begin
				check(oq[i], pb(i));
				check(lq[i], i == len - 1);
			end
			check(32'(lcat), 32'(up));
			rreg(1, RX_LEN, v);
			check(v, len);
		end
		$display("case tag %h len %0d done", tag, len);
	endtask : run

	task tally_and_finish;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish

	initial begin
		logic [31:0] v;
		lk2.data = 8'h0;
		lk2.valid = 1'b0;
		lk2.last = 1'b0;
		repeat (12) @(posedge ref_clk);
		srst <= 1'b0;
		rreg(0, TX_FRAG, v);
		check(v, 32'(FRAG_RST));
		rreg(0, TX_TAG, v);
		check(v, 32'(TAG_RST));
		rreg(1, 3'h7, v);
		check(v, 32'h0);
		$display("reset values done");
		run(0, 0, 24'h123456, 10, 4, 1);
		run(0, 0, 24'h000001, 3, 4, 1);
		run(0, 0, 24'hfffffe, 8, 4, 1);
		run(1, 0, 24'habcdef, 5, 8, 1);
		run(1, 0, 24'h00abcd, 9, 8, 0);
		run(0, 0, 24'h000000, 4, 4, 0);
		run(0, 1, 24'h111111, 1501, 256, 0);
		run(0, 1, 24'h111111, 1500, 256, 1);
		run(0, 0, 24'h222222, 4097, 256, 0);
		run(0, 0, 24'h222222, 4096, 1000, 1);
		wreg(1, RX_CTRL, 32'h0);
		wreg(1, RX_TAG, 32'h5a5a5a);
		snd(8'h00, 24'h5a5a5a, 2);
		rreg(2, RX_STAT, v);
		check(v[ST_ORPHAN], 1'b1);
		snd(8'hc0, 24'h000000, 2);
		rreg(2, RX_STAT, v);
		check(v[ST_TAGERR], 1'b1);
		snd(8'h40, 24'h5a5a5a, 4097);
		rreg(2, RX_STAT, v);
		check(v[ST_OVER], 1'b1);
		wreg(1, RX_STAT, 32'hf);
		snd(8'h40, 24'h5a5a5a, 5);
		snd(8'hc0, 24'h5a5a5a, 3);
		rreg(2, RX_LEN, v);
		check(v, 32'h3);
		rreg(2, RX_STAT, v);
		check(v[3:0], 4'h0);
		$display("fault cases done");
		tally_and_finish();
	end

	// Longest legal run, the 4096-byte datagram, is near 10000 cycles
	initial begin
		repeat (90000) @(posedge ref_clk);
		miscompares++;
		tally_and_finish();
	end
endmodule : tb_top
